/* File: include/ffs_regs.vh */
// Register map, field positions, reset values and timing counts of the fault supervisor
`ifndef FFS_REGS_VH
`define FFS_REGS_VH

// Register byte offsets
`define FFS_CTRL_OFS        8'h00
`define FFS_LEVEL_OFS       8'h04
`define FFS_STATUS_OFS      8'h08

// Control fields
`define FFS_CTRL_EN_BIT     0
`define FFS_CTRL_RST        1'b1
`define FFS_LEVEL_RST       10'h016D

// Status fields (bits 0 to 5 sticky, write one to clear; live over-temperature and state bits)
`define FFS_ST_OVP          0
`define FFS_ST_OPP          1
`define FFS_ST_SCP          2
`define FFS_ST_BO           3
`define FFS_ST_OTP          4
`define FFS_ST_BIF          5
`define FFS_ST_NFLAG        6
`define FFS_ST_OTP_LIVE     8
`define FFS_ST_STATE_LSB    12

// Clock and timing
`define FFS_CLK_KHZ         100000
`define FFS_BO_MS           60
`define FFS_OPP_MS          160
`define FFS_FDR_MS          1500
`define FFS_BO_CYC          (`FFS_BO_MS * `FFS_CLK_KHZ)
`define FFS_OPP_CYC         (`FFS_OPP_MS * `FFS_CLK_KHZ)
`define FFS_FDR_CYC         (`FFS_FDR_MS * `FFS_CLK_KHZ)
`define FFS_PON_NS          500
`define FFS_PPER_NS         10000
`define FFS_PON_CYC         (`FFS_PON_NS * `FFS_CLK_KHZ / 1000000)
`define FFS_PPER_CYC        (`FFS_PPER_NS * `FFS_CLK_KHZ / 1000000)

// Pulse counts
`define FFS_OVP_PULSES      2'd3
`define FFS_OTP_PULSES      3'd4
`define FFS_BI_LAST         3'd3

// Brown-out level as a fraction of brown-in: 106/128, about 83 percent
`define FFS_BO_NUM          7'd106
`define FFS_BO_SHIFT        7

`endif

/* File: rtl/ffs_supervisor.v */
// Fault supervision, line qualification and supply-hold regulator with AHB-Lite registers
//
// What this block does
// R1: Supply-hold regulator runs only while feedback demands stop for overshoot.
// R2: In supply-hold, pulse without limit while supply below 11 V, stop above.
// R3: Feedback withdraws stop request: both gates return to normal-mode control.
// R4: Supply at off threshold with over-power or low aux: short fault, long delay.
// R5: Over-voltage on three consecutive low-side pulses starts the 1.5 s delay.
// R6: Line-sense current compared against separate brown-in and brown-out levels.
// R7: Every start from undervoltage lockout emits up to four low-side test pulses.
// R8: Line result of the first test pulse is discarded.
// R9: Three low line tests: stop, wake low, restart at supply off threshold.
// R10: A qualified test pulse above brown-in proceeds to output soft-start.
// R11: Brown-out only after line low longer than 60 ms; timer restarts on clear.
// R12: Pending brown-out fault clears when supply falls to off threshold.
// R13: Low line halts switching; no restart until line qualifies again.
// R14: Brown-out level is about 83 percent of the brown-in level.
// R15: Over-power held for 160 ms enters the 1.5 s non-switching delay.
// R16: During the long delay no test pulses, only supply lockout cycling.
// R17: Hot for more than three pulses trips over-temperature, held until cool.
// R18: Pulse-count qualifiers return to zero on a pulse without their condition.
// R19: Any fault or undervoltage state keeps wake low and both gates off.
`timescale 1ns/1ns
`include "ffs_regs.vh"

module ffs_supervisor #(
    parameter LW      = 10,
    parameter BO_CYC  = `FFS_BO_CYC,
    parameter OPP_CYC = `FFS_OPP_CYC,
    parameter FDR_CYC = `FFS_FDR_CYC,
    parameter PON     = `FFS_PON_CYC,
    parameter PPER    = `FFS_PPER_CYC
) (
    input  wire          ref_clk_i,
    input  wire          reset_i,
    input  wire          hsel_i,
    input  wire [31:0]   haddr_i,
    input  wire [1:0]    htrans_i,
    input  wire          hwrite_i,
    input  wire [2:0]    hsize_i,
    input  wire [31:0]   hwdata_i,
    input  wire          hready_i,
    output reg  [31:0]   hrdata_o,
    output reg           hreadyout_o,
    output reg           hresp_o,
    input  wire          vdd_on_i,
    input  wire          vdd_off_i,
    input  wire          vdd_below_hold_i,
    input  wire          fb_stop_i,
    input  wire          aux_ov_cmp_i,
    input  wire          aux_low_cmp_i,
    input  wire          opp_cmp_i,
    input  wire          ntc_hot_i,
    input  wire          ntc_cool_i,
    input  wire [LW-1:0] line_sense_current_i,
    input  wire          normal_low_i,
    input  wire          normal_clamp_i,
    output reg           low_side_gate_pulse_o,
    output reg           clamp_gate_pulse_o,
    output reg           wake_o
);

    localparam S_UVLO = 3'd0;
    localparam S_TEST = 3'd1;
    localparam S_RUN  = 3'd2;
    localparam S_FDR  = 3'd3;
    localparam S_HALT = 3'd4;

    reg  [2:0]    state_r;
    reg  [2:0]    state_nxt;
    reg           low_nxt;
    reg           clamp_nxt;
    reg           low_d_r;
    reg  [15:0]   pg_cnt_r;
    reg  [2:0]    npulse_r;
    reg  [1:0]    ovp_cnt_r;
    reg  [2:0]    otp_cnt_r;
    reg           otp_r;
    reg           bo_pend_r;
    reg           line_low_r;
    reg  [LW-1:0] line_smp_r;
    reg  [27:0]   opp_tmr_r;
    reg  [27:0]   bo_tmr_r;
    reg  [27:0]   fdr_tmr_r;
    reg           fdr_done_r;
    reg  [5:0]    sts_r;
    reg  [5:0]    sts_set;
    reg           en_r;
    reg  [LW-1:0] bi_lvl_r;
    reg           wr_r;
    reg  [7:0]    wa_r;

    // Low-side falling edge, seen one cycle late
    wire          pulse_end = low_d_r & ~low_side_gate_pulse_o;
    wire [LW+6:0] bo_prod   = bi_lvl_r * `FFS_BO_NUM;
    // R14: brown-out level derived
    wire [LW-1:0] bo_lvl    = bo_prod[LW+6:`FFS_BO_SHIFT];
    // R6: two separate line comparisons
    wire          line_ok   = line_smp_r > bi_lvl_r;
    wire          line_bo   = line_smp_r <= bo_lvl;
    // R1: supply-hold pulsing only under feedback stop
    wire          hold_on   = (state_r == S_RUN) && fb_stop_i && vdd_below_hold_i;
    wire          gen_en    = (state_r == S_TEST) || hold_on;
    wire          gen_hi    = gen_en && (pg_cnt_r < PON[15:0]);
    wire          opp_trip  = opp_tmr_r == OPP_CYC[27:0] - 28'd1;
    wire          bo_trip   = bo_tmr_r == BO_CYC[27:0];
    wire          ovp_trip  = pulse_end && aux_ov_cmp_i && (ovp_cnt_r == `FFS_OVP_PULSES - 2'd1);
    wire          otp_trip  = pulse_end && ntc_hot_i && (otp_cnt_r == `FFS_OTP_PULSES - 3'd1);
    wire          scp_trip  = vdd_off_i && (opp_cmp_i || aux_low_cmp_i);
    wire          take      = hsel_i && htrans_i[1] && hready_i;

    always @* begin
        state_nxt = state_r;
        sts_set   = 6'd0;
        case (state_r)
            S_UVLO: begin
                if (en_r && vdd_on_i) begin
                    state_nxt = S_TEST;
                end
            end
            S_TEST: begin
                if (vdd_off_i) begin
                    state_nxt = S_UVLO;
                // R8: first test result ignored
                end else if (pulse_end && npulse_r != 3'd0) begin
                    // R10: qualified pulse starts soft-start
                    if (line_ok) begin
                        state_nxt = S_RUN;
                    // R9: three low tests halt
                    end else if (npulse_r == `FFS_BI_LAST) begin
                        state_nxt = S_HALT;
                        sts_set[`FFS_ST_BIF] = 1'b1;
                    end
                end
            end
            S_RUN: begin
                // R4: short detected at supply off threshold
                if (scp_trip) begin
                    state_nxt = S_FDR;
                    sts_set[`FFS_ST_SCP] = 1'b1;
                end else if (vdd_off_i) begin
                    state_nxt = S_UVLO;
                // R5: over-voltage starts long delay
                end else if (ovp_trip) begin
                    state_nxt = S_FDR;
                    sts_set[`FFS_ST_OVP] = 1'b1;
                // R17: over-temperature trip
                end else if (otp_trip) begin
                    state_nxt = S_HALT;
                    sts_set[`FFS_ST_OTP] = 1'b1;
                // R15: sustained over-power
                end else if (opp_trip) begin
                    state_nxt = S_FDR;
                    sts_set[`FFS_ST_OPP] = 1'b1;
                // R13: low line halts switching
                end else if (bo_pend_r) begin
                    state_nxt = S_HALT;
                    sts_set[`FFS_ST_BO] = 1'b1;
                end
            end
            S_FDR: begin
                if (fdr_done_r && vdd_off_i) begin
                    state_nxt = S_UVLO;
                end
            end
            S_HALT: begin
                // R17: held until release comparator
                if (vdd_off_i && !otp_r) begin
                    state_nxt = S_UVLO;
                end
            end
            default: begin
                state_nxt = S_UVLO;
            end
        endcase
    end

    always @* begin
        low_nxt   = 1'b0;
        clamp_nxt = 1'b0;
        // R7: test pulses in every start cycle
        if (state_nxt == S_TEST && state_r == S_TEST) begin
            low_nxt = gen_hi;
        end else if (state_nxt == S_RUN && state_r == S_RUN) begin
            // R2: unlimited pulses below hold level
            if (fb_stop_i) begin
                low_nxt = hold_on && gen_hi;
            // R3: normal mode control restored
            end else begin
                low_nxt   = normal_low_i;
                clamp_nxt = normal_clamp_i;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r               <= S_UVLO;
            low_side_gate_pulse_o <= 1'b0;
            clamp_gate_pulse_o    <= 1'b0;
            wake_o                <= 1'b0;
            low_d_r               <= 1'b0;
            pg_cnt_r              <= 16'd0;
            npulse_r              <= 3'd0;
            line_smp_r            <= {LW{1'b0}};
        end else begin
            state_r               <= state_nxt;
            // R19: gates and wake off outside test and run
            low_side_gate_pulse_o <= low_nxt;
            clamp_gate_pulse_o    <= clamp_nxt;
            wake_o                <= (state_nxt == S_TEST) || (state_nxt == S_RUN);
            low_d_r               <= low_side_gate_pulse_o;
            if (!gen_en || pg_cnt_r == PPER[15:0] - 16'd1) begin
                pg_cnt_r <= 16'd0;
            end else begin
                pg_cnt_r <= pg_cnt_r + 16'd1;
            end
            // Test pulse ends, saturating count
            if (state_r != S_TEST) begin
                npulse_r <= 3'd0;
            end else if (pulse_end && npulse_r != 3'd7) begin
                npulse_r <= npulse_r + 3'd1;
            end
            // Line value held from the last high cycle
            if (low_side_gate_pulse_o) begin
                line_smp_r <= line_sense_current_i;
            end
        end
    end

    // Pulse-count qualifiers
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            ovp_cnt_r <= 2'd0;
            otp_cnt_r <= 3'd0;
            otp_r     <= 1'b0;
        end else begin
            if (state_r != S_RUN) begin
                ovp_cnt_r <= 2'd0;
                otp_cnt_r <= 3'd0;
            end else if (pulse_end) begin
                // R18: qualifiers clear on a clean pulse
                ovp_cnt_r <= aux_ov_cmp_i ? ovp_cnt_r + 2'd1 : 2'd0;
                otp_cnt_r <= ntc_hot_i ? otp_cnt_r + 3'd1 : 3'd0;
            end
            // Over-temperature latch, set wins over release
            if (otp_trip && state_r == S_RUN) begin
                otp_r <= 1'b1;
            end else if (ntc_cool_i) begin
                otp_r <= 1'b0;
            end
        end
    end

    // Millisecond timers
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            opp_tmr_r  <= 28'd0;
            bo_tmr_r   <= 28'd0;
            fdr_tmr_r  <= 28'd0;
            fdr_done_r <= 1'b0;
            bo_pend_r  <= 1'b0;
            line_low_r <= 1'b0;
        end else begin
            // R15: over-power timer restarts on clear
            if (state_r == S_RUN && opp_cmp_i && !opp_trip) begin
                opp_tmr_r <= opp_tmr_r + 28'd1;
            end else begin
                opp_tmr_r <= 28'd0;
            end
            if (state_r != S_RUN) begin
                line_low_r <= 1'b0;
            end else if (pulse_end) begin
                line_low_r <= line_bo;
            end
            // R11: brown-out timer, restarts when line clears
            if (state_r == S_RUN && line_low_r && !bo_trip) begin
                bo_tmr_r <= bo_tmr_r + 28'd1;
            end else begin
                bo_tmr_r <= 28'd0;
            end
            // R12: pending brown-out cleared at off threshold
            if (bo_trip) begin
                bo_pend_r <= 1'b1;
            end else if (vdd_off_i) begin
                bo_pend_r <= 1'b0;
            end
            // R16: long delay counts without pulsing
            if (state_r != S_FDR) begin
                fdr_tmr_r  <= 28'd0;
                fdr_done_r <= 1'b0;
            end else if (fdr_tmr_r == FDR_CYC[27:0] - 28'd1) begin
                fdr_done_r <= 1'b1;
            end else begin
                fdr_tmr_r <= fdr_tmr_r + 28'd1;
            end
        end
    end

    // AHB-Lite register slave, zero wait states
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
            wr_r        <= 1'b0;
            wa_r        <= 8'h00;
            en_r        <= `FFS_CTRL_RST;
            bi_lvl_r    <= `FFS_LEVEL_RST;
            sts_r       <= 6'd0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            // Write address held for the data phase
            wr_r        <= take && hwrite_i;
            wa_r        <= haddr_i[7:0];
            hrdata_o    <= 32'h0000_0000;
            if (take && !hwrite_i) begin
                if (haddr_i[7:0] == `FFS_CTRL_OFS) begin
                    hrdata_o[`FFS_CTRL_EN_BIT] <= en_r;
                end else if (haddr_i[7:0] == `FFS_LEVEL_OFS) begin
                    hrdata_o[LW-1:0] <= bi_lvl_r;
                end else if (haddr_i[7:0] == `FFS_STATUS_OFS) begin
                    hrdata_o[`FFS_ST_NFLAG-1:0]   <= sts_r;
                    hrdata_o[`FFS_ST_OTP_LIVE]    <= otp_r;
                    hrdata_o[`FFS_ST_STATE_LSB+2:`FFS_ST_STATE_LSB] <= state_r;
                end
            end
            if (wr_r && wa_r == `FFS_CTRL_OFS) begin
                en_r <= hwdata_i[`FFS_CTRL_EN_BIT];
            end
            if (wr_r && wa_r == `FFS_LEVEL_OFS) begin
                bi_lvl_r <= hwdata_i[LW-1:0];
            end
            // Set wins over a same-cycle clear
            if (wr_r && wa_r == `FFS_STATUS_OFS) begin
                sts_r <= (sts_r & ~hwdata_i[`FFS_ST_NFLAG-1:0]) | sts_set;
            end else begin
                sts_r <= sts_r | sts_set;
            end
        end
    end

endmodule

/* File: testbench/ffs_supervisor_properties.sv */
// Port-level properties of the fault supervisor
`timescale 1ns/1ns
module ffs_supervisor_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        hsel_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        vdd_on_i,
    input wire logic        vdd_off_i,
    input wire logic        fb_stop_i,
    input wire logic        low_side_gate_pulse_o,
    input wire logic        clamp_gate_pulse_o,
    input wire logic        wake_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_test_start;
        ##[0:3] low_side_gate_pulse_o ##1 low_side_gate_pulse_o;
    endsequence
    chk_reset_quiet: assert property (
        $fell(reset_i) |-> !wake_o && !low_side_gate_pulse_o && !clamp_gate_pulse_o)
        else $error("outputs active after reset");
    chk_idle_gates: assert property (
        !wake_o |-> !low_side_gate_pulse_o && !clamp_gate_pulse_o)
        else $error("gate active while wake low");
    chk_wake_cause: assert property (
        $rose(wake_o) |-> $past(vdd_on_i))
        else $error("wake rose without supply on");
    chk_test_pulses: assert property (
        $rose(wake_o) |-> s_test_start)
        else $error("no test pulse after wake");
    chk_off_drops_wake: assert property (
        vdd_off_i && wake_o |=> !wake_o)
        else $error("wake kept at supply off");
    chk_hold_no_clamp: assert property (
        fb_stop_i |=> !clamp_gate_pulse_o)
        else $error("clamp gate during stop request");
    chk_ready_after: assert property (
        !reset_i |=> hreadyout_o)
        else $error("bus not ready");
    chk_resp_okay: assert property (
        !hresp_o)
        else $error("bus response not okay");
    chk_rdata_idle: assert property (
        !$past(hsel_i && htrans_i[1] && hready_i) |-> hrdata_o == 32'h0000_0000)
        else $error("read data outside data phase");
endmodule
bind ffs_supervisor ffs_supervisor_chk u_chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .vdd_on_i(vdd_on_i), .vdd_off_i(vdd_off_i), .fb_stop_i(fb_stop_i),
    .low_side_gate_pulse_o(low_side_gate_pulse_o), .clamp_gate_pulse_o(clamp_gate_pulse_o),
    .wake_o(wake_o));

/* File: testbench/ffs_stage_model.sv */
// Power stage and feedback loop model: normal gate commands and pulse count
`timescale 1ns/1ns
module ffs_stage_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        gate_i,
    input  wire logic        clr_i,
    output logic             low_o,
    output logic             clamp_o,
    output logic [15:0]      count_o
);
    logic [3:0] ph;
    logic       gate_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 4'h0;
            low_o <= 1'b0;
            clamp_o <= 1'b0;
            gate_q <= 1'b0;
            count_o <= 16'h0000;
        end else begin
            ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
            low_o <= (ph < 4'h3);
            clamp_o <= (ph >= 4'h4) && (ph < 4'h8);
            gate_q <= gate_i;
            // Counts rising low-side edges
            if (clr_i)
                count_o <= 16'h0000;
            else if (gate_i && !gate_q)
                count_o <= count_o + 16'h0001;
        end
    end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the fault supervisor
`timescale 1ns/1ns
module testbench;
    logic        ref_clk_i, reset_i, hwrite, hready, pclr, low, clamp, wake, nlow, nclamp;
    logic        hsel, hresp;
    logic [2:0]  hsize;
    logic        vdd_on, vdd_off, below, fb_stop, aux_ov, aux_low, over_power_fault, hot, cool;
    logic [1:0]  htrans, nq;
    logic [9:0]  line;
    logic [15:0] pcnt;
    logic [31:0] haddr, hwdata, hrdata, r;
    int          bad_count, n_checks, k;
    ffs_supervisor #(.BO_CYC(200), .OPP_CYC(300), .FDR_CYC(500), .PON(3), .PPER(10)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .vdd_on_i(vdd_on), .vdd_off_i(vdd_off), .vdd_below_hold_i(below),
        .fb_stop_i(fb_stop), .aux_ov_cmp_i(aux_ov), .aux_low_cmp_i(aux_low),
        .opp_cmp_i(over_power_fault), .ntc_hot_i(hot), .ntc_cool_i(cool), .line_sense_current_i(line),
        .normal_low_i(nlow), .normal_clamp_i(nclamp), .low_side_gate_pulse_o(low),
        .clamp_gate_pulse_o(clamp), .wake_o(wake));
    ffs_stage_model pm (.clk_i(ref_clk_i), .rst_i(reset_i), .gate_i(low), .clr_i(pclr),
        .low_o(nlow), .clamp_o(nclamp), .count_o(pcnt));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge ref_clk_i);
        while (hready !== 1'b1) @(posedge ref_clk_i);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk_i);
        while (hready !== 1'b1) @(posedge ref_clk_i);
        q = hrdata;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task rst;
        reset_i <= 1'b1;
        {vdd_on, vdd_off, below, fb_stop, aux_ov, aux_low, over_power_fault, hot, cool} <= 9'h000;
        line <= 10'h190;
        cyc(16);
        reset_i <= 1'b0;
        cyc(2);
    endtask
    task wlow(input logic v);
        for (k = 0; k < 3000 && low !== v; k++) @(posedge ref_clk_i);
    endtask
    // One low-side pulse end
    task pend;
        wlow(1'b1);
        wlow(1'b0);
    endtask
    task clr;
        pclr <= 1'b1;
        cyc(1);
        pclr <= 1'b0;
    endtask
    task wst(input logic [31:0] e);
        int i;
        for (i = 0; i < 400; i++) begin
            ahb(1'b0, 8'h08, 32'h0000_0000, r);
            if (r[14:12] === e[14:12]) break;
        end
        chk("status", r, e);
    endtask
    task to_run;
        vdd_on <= 1'b1;
        wst(32'h0000_2000);
        vdd_on <= 1'b0;
    endtask
    initial begin
        {haddr, hwdata, htrans, hwrite, pclr, hsel} = 69'h0;
        hsize = 3'h2;
        rst;
        ahb(1'b0, 8'h00, 32'h0000_0000, r);
        chk("ctrl", r, 32'h0000_0001);
        ahb(1'b0, 8'h04, 32'h0000_0000, r);
        chk("level", r, 32'h0000_016D);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, r);
        ahb(1'b0, 8'h0C, 32'h0000_0000, r);
        chk("unmapped", r, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'h0000_0000, r);
        vdd_on <= 1'b1;
        cyc(30);
        chk("disabled wake", wake, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'h0000_0001, r);
        pend;
        line <= 10'h0C8;
        wst(32'h0000_4020);
        chk("test pulses", pcnt, 32'h0000_0004);
        chk("halt wake", wake, 32'h0000_0000);
        vdd_on <= 1'b0;
        vdd_off <= 1'b1;
        wst(32'h0000_0020);
        ahb(1'b1, 8'h08, 32'h0000_0020, r);
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("flag clear", r, 32'h0000_0000);
        // Supply-hold regulator, then normal commands
        rst;
        to_run;
        fb_stop <= 1'b1;
        cyc(3);
        clr;
        cyc(40);
        chk("hold idle", pcnt, 32'h0000_0000);
        below <= 1'b1;
        cyc(40);
        chk("hold pulses", pcnt >= 16'h0003, 32'h0000_0001);
        below <= 1'b0;
        cyc(3);
        clr;
        cyc(40);
        chk("hold stop", pcnt, 32'h0000_0000);
        fb_stop <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        nq = {nlow, nclamp};
        for (k = 0; k < 30; k++) begin
            @(negedge ref_clk_i);
            chk("normal gates", {low, clamp}, nq);
            nq = {nlow, nclamp};
        end
        @(posedge ref_clk_i);
        aux_ov <= 1'b1;
        pend;
        pend;
        aux_ov <= 1'b0;
        pend;
        aux_ov <= 1'b1;
        pend;
        pend;
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("ovp broken run", r, 32'h0000_2000);
        pend;
        wst(32'h0000_3001);
        clr;
        cyc(400);
        chk("fdr pulses", pcnt, 32'h0000_0000);
        aux_ov <= 1'b0;
        vdd_off <= 1'b1;
        wst(32'h0000_0001);
        rst;
        to_run;
        over_power_fault <= 1'b1;
        cyc(200);
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("opp early", r, 32'h0000_2000);
        wst(32'h0000_3002);
        rst;
        to_run;
        aux_low <= 1'b1;
        vdd_off <= 1'b1;
        wst(32'h0000_3004);
        // Line dips: above brown-out level, then a broken low spell
        rst;
        to_run;
        line <= 10'h14A;
        cyc(250);
        line <= 10'h0FA;
        cyc(150);
        line <= 10'h190;
        cyc(30);
        line <= 10'h0FA;
        cyc(150);
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("bo early", r, 32'h0000_2000);
        wst(32'h0000_4008);
        line <= 10'h190;
        vdd_off <= 1'b1;
        wst(32'h0000_0008);
        vdd_off <= 1'b0;
        ahb(1'b1, 8'h08, 32'h0000_0008, r);
        to_run;
        cyc(20);
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("bo cleared", r, 32'h0000_2000);
        chk("resp", hresp, 32'h0000_0000);
        rst;
        to_run;
        hot <= 1'b1;
        wst(32'h0000_4110);
        hot <= 1'b0;
        vdd_off <= 1'b1;
        cyc(20);
        ahb(1'b0, 8'h08, 32'h0000_0000, r);
        chk("otp held", r, 32'h0000_4110);
        cool <= 1'b1;
        wst(32'h0000_0010);
        results;
    end
    initial begin
        cyc(60000);
        bad_count++;
        results;
    end
endmodule
